// ---- verilog/smb_client.sv ----
// serial bus client with per-transaction protocol selection
//
// Overview of operation
// - protocol picked per transaction, then held fixed
// - 50ms hold keeps last protocol after transaction
// - bus start disables the alternate link logic except in an alternate transaction or its hold
// - host may stretch clock; device never drives it
// - start is data falling while clock high
// - first byte: 7-bit address plus direction bit
// - strap latched once: address and sensor mode
// - wrong address or protocol: no ack, no change
// - bytes are eight bits, most significant first
// - ack index and data bytes, own address, alert query; a fourth byte is refused
// - stop resets client state during bus transaction
// - 30ms without activity resets the bus interface
// - send, write, read, receive byte and alert query
// - write byte: address, index, data stored
// - read byte: index, repeated start, read, nack
// - send byte sets pointer; receive byte reads it
// - alert query returns address, clears interrupt enable
`timescale 1ns/1ns
module smb_client
  import smb_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic serial_bus_clock_pin,
  output logic serial_bus_clock_pin_out,
  output logic serial_bus_clock_pin_oe,
  input wire logic serial_bus_data_pin,
  output logic serial_bus_data_pin_out,
  output logic serial_bus_data_pin_oe,
  input wire logic alternate_link_clock_pin,
  output logic alternate_link_enable,
  input wire logic [1:0] address_and_sensor_strap,
  output logic remote1_thermistor_mode,
  input wire logic alert_event,
  output logic alert_interrupt_out_n,
  output logic interrupt_output_enable
);

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam int ALT_W = $clog2(ALT_IDLE_CYCLES + 1);

  function automatic logic [6:0] strap_address(input logic [1:0] strap);
    strap_address = strap[STRAP_ADDR_BIT] ? ADDR_STRAP_B : ADDR_STRAP_A;
  endfunction : strap_address

  // ---------------------------------------------------------------
  // pin synchronisers and edge detection
  // ---------------------------------------------------------------
  logic [1:0] scl_sync, sda_sync, alt_sync, strap_s1, strap_s2;
  logic scl_prev, sda_prev, alt_prev;

  always_ff @(posedge clock) begin
    if (rst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      alt_sync <= 2'h0;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
      alt_prev <= 1'b0;
    end else begin
      scl_sync <= {scl_sync[0], serial_bus_clock_pin};
      sda_sync <= {sda_sync[0], serial_bus_data_pin};
      alt_sync <= {alt_sync[0], alternate_link_clock_pin};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
      alt_prev <= alt_sync[1];
    end
  end

  always_ff @(posedge clock) begin
    strap_s1 <= address_and_sensor_strap;
    strap_s2 <= strap_s1;
  end

  logic scl, sda, scl_rise, scl_fall, bus_start, bus_stop, bus_edge, alt_edge;
  assign scl = scl_sync[1];
  assign sda = sda_sync[1];
  assign scl_rise = scl & ~scl_prev;
  assign scl_fall = ~scl & scl_prev;
  assign bus_start = scl & scl_prev & sda_prev & ~sda;
  assign bus_stop = scl & scl_prev & ~sda_prev & sda;
  assign bus_edge = (scl ^ scl_prev) | (sda ^ sda_prev);
  assign alt_edge = alt_sync[1] ^ alt_prev;

  // ---------------------------------------------------------------
  // strap capture
  // ---------------------------------------------------------------
  logic [1:0] strap_wait;
  logic strap_done;
  logic [6:0] own_addr;

  always_ff @(posedge clock) begin
    if (rst) begin
      strap_wait <= 2'h0;
      strap_done <= 1'b0;
      own_addr <= ADDR_STRAP_A;
      remote1_thermistor_mode <= 1'b0;
    end else if (!strap_done) begin
      // wait until the synchroniser holds the pin, then keep it for good
      if (strap_wait == STRAP_SETTLE) begin
        strap_done <= 1'b1;
        own_addr <= strap_address(strap_s2);
        remote1_thermistor_mode <= strap_s2[STRAP_THERM_BIT];
      end else begin
        strap_wait <= strap_wait + 2'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // timebase, hold and time-out
  // ---------------------------------------------------------------
  logic [TICK_W-1:0] tick_cnt;
  logic tick;
  assign tick = (tick_cnt == TICK_W'(TICK_CYCLES - 1));

  always_ff @(posedge clock) begin
    if (rst || tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + TICK_W'(1);
    end
  end

  smb_proto_t proto, last_proto;
  logic [5:0] hold_cnt, idle_ticks;
  logic [ALT_W-1:0] alt_idle;
  logic smb_timeout, smb_end, alt_end, start_ok, alt_begin, hold_free;

  assign smb_timeout = (proto == SMB_PROTO_SERIAL) && (idle_ticks == TIMEOUT_TICKS);
  assign smb_end = (proto == SMB_PROTO_SERIAL) && (bus_stop || smb_timeout);
  assign alt_end = (proto == SMB_PROTO_ALT) && (alt_idle == ALT_W'(ALT_IDLE_CYCLES));
  assign hold_free = (hold_cnt == 6'h0);
  // inside the hold window only the previous protocol may begin
  assign start_ok = bus_start && ((proto == SMB_PROTO_SERIAL) ||
                    ((proto == SMB_PROTO_NONE) && (hold_free || last_proto == SMB_PROTO_SERIAL)));
  assign alt_begin = alt_edge && (proto == SMB_PROTO_NONE) && !bus_start &&
                     (hold_free || last_proto == SMB_PROTO_ALT);

  always_ff @(posedge clock) begin
    if (rst || bus_edge || proto != SMB_PROTO_SERIAL) begin
      idle_ticks <= 6'h0;
    end else if (tick && idle_ticks != TIMEOUT_TICKS) begin
      idle_ticks <= idle_ticks + 6'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || alt_edge || proto != SMB_PROTO_ALT) begin
      alt_idle <= '0;
    end else if (alt_idle != ALT_W'(ALT_IDLE_CYCLES)) begin
      alt_idle <= alt_idle + ALT_W'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      proto <= SMB_PROTO_NONE;
      last_proto <= SMB_PROTO_NONE;
      hold_cnt <= 6'h0;
    end else if (smb_end || alt_end) begin
      proto <= SMB_PROTO_NONE;
      hold_cnt <= HOLD_TICKS;
    end else if (start_ok && proto == SMB_PROTO_NONE) begin
      proto <= SMB_PROTO_SERIAL;
      last_proto <= SMB_PROTO_SERIAL;
    end else if (alt_begin) begin
      proto <= SMB_PROTO_ALT;
      last_proto <= SMB_PROTO_ALT;
    end else if (proto == SMB_PROTO_NONE && tick && !hold_free) begin
      hold_cnt <= hold_cnt - 6'h1;
    end
  end

  assign alternate_link_enable = (proto == SMB_PROTO_ALT);
  assign serial_bus_clock_pin_out = 1'b0;
  assign serial_bus_clock_pin_oe = 1'b0;

  // ---------------------------------------------------------------
  // byte engine
  // ---------------------------------------------------------------
  smb_mem_if mem_port ();
  smb_reg_mem u_mem (
    .clock(clock),
    .port(mem_port)
  );

  smb_state_t state;
  logic [3:0] bit_cnt;
  logic [1:0] byte_idx;
  logic [7:0] shift, tx_shift, pointer;
  logic sda_drive, reading_ara, alert_pending;
  logic [7:0] rx_byte, read_value;
  logic addr_match, ara_match, byte_ack;

  assign rx_byte = shift;
  assign addr_match = (rx_byte[7:1] == own_addr);
  assign ara_match = (rx_byte[7:1] == ALERT_RESPONSE_ADDR) && rx_byte[0] && !alert_interrupt_out_n;
  // address byte acks on match; index and data bytes always ack; a fourth byte is refused
  assign byte_ack = (byte_idx == IDX_ADDR) ? (addr_match || ara_match) : (byte_idx != 2'h3);
  assign read_value = (pointer == INTERRUPT_OUTPUT_ENABLE_INDEX) ?
                      {mem_port.rdata[7:1], interrupt_output_enable} : mem_port.rdata;

  assign mem_port.raddr = pointer;
  assign mem_port.waddr = pointer;
  assign mem_port.wdata = rx_byte;
  assign mem_port.we = (state == SMB_ST_RX) && scl_fall && (bit_cnt == BYTE_BITS) &&
                       (byte_idx == IDX_DATA) && !start_ok && !smb_end;

  always_ff @(posedge clock) begin
    if (rst || smb_end) begin
      state <= SMB_ST_IDLE;
      sda_drive <= 1'b0;
      bit_cnt <= 4'h0;
      byte_idx <= IDX_ADDR;
      reading_ara <= 1'b0;
      shift <= 8'h00;
      tx_shift <= 8'h00;
    end else if (start_ok) begin
      state <= SMB_ST_RX;
      sda_drive <= 1'b0;
      bit_cnt <= 4'h0;
      byte_idx <= IDX_ADDR;
      reading_ara <= 1'b0;
    end else begin
      unique case (state)
        SMB_ST_IDLE, SMB_ST_IGNORE: begin
          sda_drive <= 1'b0;
        end
        SMB_ST_RX: begin
          if (scl_rise) begin
            shift <= {shift[6:0], sda};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == BYTE_BITS) begin
            if (byte_ack) begin
              sda_drive <= 1'b1;
              state <= SMB_ST_RX_ACK;
            end else begin
              state <= SMB_ST_IGNORE;
            end
          end
        end
        SMB_ST_RX_ACK: begin
          if (scl_fall) begin
            bit_cnt <= 4'h0;
            if (byte_idx == IDX_ADDR && rx_byte[0]) begin
              // read: first bit goes out on the same falling edge that ends the ack
              reading_ara <= ara_match;
              tx_shift <= ara_match ? {own_addr, 1'b0} : read_value;
              sda_drive <= ara_match ? ~own_addr[6] : ~read_value[7];
              state <= SMB_ST_TX;
            end else begin
              sda_drive <= 1'b0;
              byte_idx <= byte_idx + 2'h1;
              state <= SMB_ST_RX;
            end
          end
        end
        SMB_ST_TX: begin
          if (scl_fall) begin
            bit_cnt <= bit_cnt + 4'h1;
            tx_shift <= {tx_shift[6:0], 1'b0};
            if (bit_cnt == BYTE_BITS - 4'h1) begin
              sda_drive <= 1'b0;
              state <= SMB_ST_TX_ACK;
            end else begin
              sda_drive <= ~tx_shift[6];
            end
          end
        end
        SMB_ST_TX_ACK: begin
          // host not-acknowledges the single byte; nothing more is sent either way
          if (scl_rise) begin
            state <= SMB_ST_IGNORE;
          end
        end
        default: begin
          state <= SMB_ST_IDLE;
        end
      endcase
    end
  end

  assign serial_bus_data_pin_out = 1'b0;
  assign serial_bus_data_pin_oe = sda_drive & (proto == SMB_PROTO_SERIAL);

  // ---------------------------------------------------------------
  // register pointer and alert interrupt
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      pointer <= 8'h00;
    end else if (state == SMB_ST_RX && scl_fall && bit_cnt == BYTE_BITS && byte_idx == IDX_INDEX &&
                 !start_ok && !smb_end) begin
      pointer <= rx_byte;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      interrupt_output_enable <= INTERRUPT_OUTPUT_ENABLE_RESET;
    end else if (state == SMB_ST_TX && reading_ara && scl_fall && bit_cnt == BYTE_BITS - 4'h1) begin
      interrupt_output_enable <= 1'b0;
    end else if (mem_port.we && pointer == INTERRUPT_OUTPUT_ENABLE_INDEX) begin
      interrupt_output_enable <= rx_byte[INTERRUPT_OUTPUT_ENABLE_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      alert_pending <= 1'b0;
    end else if (alert_event) begin
      alert_pending <= 1'b1;
    end
  end

  assign alert_interrupt_out_n = ~(alert_pending & interrupt_output_enable);

endmodule : smb_client

// ---- verilog/smb_pkg.sv ----
// shared constants for the serial bus client front end
package smb_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned TICK_NS = 1_000_000;
  localparam int unsigned TICK_CYCLES_DEF = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned HOLD_MS = 50;
  localparam int unsigned TIMEOUT_MS = 30;
  localparam logic [5:0] HOLD_TICKS = 6'(HOLD_MS);
  // one tick more so that a partial first tick never shortens the wait
  localparam logic [5:0] TIMEOUT_TICKS = 6'(TIMEOUT_MS + 1);
  localparam int unsigned ALT_IDLE_NS = 100_000;
  localparam int unsigned ALT_IDLE_CYCLES = ALT_IDLE_NS / CLK_PERIOD_NS;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // ---------------------------------------------------------------
  // addresses and fields
  // ---------------------------------------------------------------
  localparam logic [6:0] ADDR_STRAP_A = 7'h2f;
  localparam logic [6:0] ADDR_STRAP_B = 7'h2e;
  localparam logic [6:0] ALERT_RESPONSE_ADDR = 7'h0c;
  localparam logic [7:0] INTERRUPT_OUTPUT_ENABLE_INDEX = 8'h03;
  localparam int unsigned INTERRUPT_OUTPUT_ENABLE_BIT = 0;
  localparam logic INTERRUPT_OUTPUT_ENABLE_RESET = 1'b1;
  localparam int unsigned STRAP_THERM_BIT = 1;
  localparam int unsigned STRAP_ADDR_BIT = 0;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] IDX_ADDR = 2'h0;
  localparam logic [1:0] IDX_INDEX = 2'h1;
  localparam logic [1:0] IDX_DATA = 2'h2;

  typedef enum logic [1:0] {
    SMB_PROTO_NONE = 2'b00,
    SMB_PROTO_SERIAL = 2'b01,
    SMB_PROTO_ALT = 2'b10
  } smb_proto_t;

  typedef enum logic [2:0] {
    SMB_ST_IDLE = 3'b000,
    SMB_ST_RX = 3'b001,
    SMB_ST_RX_ACK = 3'b010,
    SMB_ST_TX = 3'b011,
    SMB_ST_TX_ACK = 3'b100,
    SMB_ST_IGNORE = 3'b101
  } smb_state_t;

endpackage : smb_pkg

// ---- verilog/smb_mem_if.sv ----
// register storage port between the bus client and its memory
`timescale 1ns/1ns
interface smb_mem_if;
  logic we;
  logic [7:0] waddr;
  logic [7:0] wdata;
  logic [7:0] raddr;
  logic [7:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : smb_mem_if

// ---- verilog/smb_reg_mem.sv ----
// 256 by 8 register storage with registered read data
`timescale 1ns/1ns
module smb_reg_mem
  import smb_pkg::*;
(
  input wire logic clock,
  smb_mem_if.mem port
);

  logic [7:0] store [0:255];

  always_ff @(posedge clock) begin
    if (port.we) begin
      store[port.waddr] <= port.wdata;
    end
  end

  always_ff @(posedge clock) begin
    port.rdata <= store[port.raddr];
  end

endmodule : smb_reg_mem

// ---- verif/smb_client_asserts.sv ----
// port-level assertions for the serial bus client
`timescale 1ns/1ns
module smb_client_asserts
  import smb_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 20
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic serial_bus_clock_pin,
  input wire logic serial_bus_clock_pin_oe,
  input wire logic serial_bus_data_pin,
  input wire logic serial_bus_data_pin_oe,
  input wire logic alternate_link_clock_pin,
  input wire logic alternate_link_enable,
  input wire logic [1:0] address_and_sensor_strap,
  input wire logic remote1_thermistor_mode,
  input wire logic alert_event,
  input wire logic alert_interrupt_out_n,
  input wire logic interrupt_output_enable
);
  // margins cover the pin synchronisers and a partial first tick
  localparam int TO_LIMIT = (int'(TIMEOUT_TICKS) + 1) * TICK_CYCLES + 10;
  localparam int ALT_LIMIT = ALT_IDLE_CYCLES + 30;
  logic [15:0] bus_idle;
  logic [15:0] alt_idle;
  logic [3:0] since_rst;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  always_ff @(posedge clock) begin
    if (rst || $changed(serial_bus_clock_pin) || $changed(serial_bus_data_pin)) begin
      bus_idle <= 16'h0000;
    end else if (bus_idle != 16'hffff) begin
      bus_idle <= bus_idle + 16'h0001;
    end
  end
  always_ff @(posedge clock) begin
    if (rst || $changed(alternate_link_clock_pin)) begin
      alt_idle <= 16'h0000;
    end else if (alt_idle != 16'hffff) begin
      alt_idle <= alt_idle + 16'h0001;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      since_rst <= 4'h0;
    end else if (since_rst != 4'hf) begin
      since_rst <= since_rst + 4'h1;
    end
  end
  chk_clock_free: assert property (!serial_bus_clock_pin_oe)
    else $error("device drove the bus clock");
  chk_alt_excl: assert property (serial_bus_data_pin_oe |-> !alternate_link_enable)
    else $error("data driven while alternate link active");
  chk_ack_clock_low: assert property ($changed(serial_bus_data_pin_oe) |-> !serial_bus_clock_pin)
    else $error("data drive changed with bus clock high");
  chk_bus_timeout: assert property (int'(bus_idle) == TO_LIMIT |-> !serial_bus_data_pin_oe)
    else $error("data still driven after bus time-out");
  chk_alt_release: assert property (int'(alt_idle) == ALT_LIMIT |-> !alternate_link_enable)
    else $error("alternate link held after idle end");
  chk_strap_mode: assert property (since_rst == 4'hc |->
    remote1_thermistor_mode == address_and_sensor_strap[STRAP_THERM_BIT] ##1 $stable(remote1_thermistor_mode))
    else $error("sensor mode not taken from strap");
  chk_irq_raise: assert property (alert_event && interrupt_output_enable |->
    ##[1:3] (!alert_interrupt_out_n || !interrupt_output_enable))
    else $error("alert output not asserted");
  chk_reset_idle: assert property (@(posedge clock) disable iff (1'b0) $fell(rst) |->
    !serial_bus_data_pin_oe && !alternate_link_enable && interrupt_output_enable && alert_interrupt_out_n)
    else $error("outputs not idle after reset");
endmodule : smb_client_asserts

bind smb_client smb_client_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_smb_client_asserts (
  .clock(clock), .rst(rst), .serial_bus_clock_pin(serial_bus_clock_pin),
  .serial_bus_clock_pin_oe(serial_bus_clock_pin_oe), .serial_bus_data_pin(serial_bus_data_pin),
  .serial_bus_data_pin_oe(serial_bus_data_pin_oe), .alternate_link_clock_pin(alternate_link_clock_pin),
  .alternate_link_enable(alternate_link_enable), .address_and_sensor_strap(address_and_sensor_strap),
  .remote1_thermistor_mode(remote1_thermistor_mode), .alert_event(alert_event),
  .alert_interrupt_out_n(alert_interrupt_out_n), .interrupt_output_enable(interrupt_output_enable));

// ---- verif/smb_host_model.sv ----
// behavioural host controller on the open-drain bus
`timescale 1ns/1ns
module smb_host_model (
  input wire logic clock,
  input wire logic sda,
  output logic scl_rel,
  output logic sda_rel
);
  // quarter bit of 10 cycles gives 250 kHz
  localparam int Q = 10;
  int stretch = 0;
  initial begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge clock);
  endtask : wait_n
  task automatic edge_pair(input logic a, input logic b);
    sda_rel = a;
    wait_n(Q);
    scl_rel = 1'b1;
    wait_n(Q);
    sda_rel = b;
    wait_n(Q);
  endtask : edge_pair
  task automatic start_cond();
    edge_pair(1'b1, 1'b0);
    scl_rel = 1'b0;
    wait_n(Q);
  endtask : start_cond
  task automatic stop_cond();
    edge_pair(1'b0, 1'b1);
  endtask : stop_cond
  // a long low phase stands for the host stretching the clock
  task automatic bit_clk(input logic b, output logic s);
    sda_rel = b;
    wait_n(Q + stretch);
    scl_rel = 1'b1;
    wait_n(Q);
    s = sda;
    wait_n(Q);
    scl_rel = 1'b0;
    wait_n(Q);
  endtask : bit_clk
  task automatic put_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_clk(v[i], s);
    bit_clk(1'b1, s);
    ack = ~s;
  endtask : put_byte
  task automatic get_byte(input logic nack, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) bit_clk(1'b1, v[i]);
    bit_clk(nack, s);
  endtask : get_byte
endmodule : smb_host_model

// ---- verif/testbench.sv ----
// self-checking bench for the serial bus client
`timescale 1ns/1ns
module testbench
  import smb_pkg::*;
;
  // short tick: hold is 50 ticks of 20 cycles
  localparam int WAIT_CYC = int'(HOLD_TICKS) * 20 + 100;
  logic clock = 1'b0;
  logic rst;
  logic alt_clk;
  logic alert_event;
  logic [1:0] strap;
  logic scl_oe, scl_out, sda_oe, sda_out, alt_en, therm, irq_n, irq_en, scl_rel, sda_rel, k;
  logic [7:0] d;
  logic [6:0] own = ADDR_STRAP_A;
  int miscompares = 0;
  int compares = 0;
  // released lines float high through the pull-ups
  wire scl = scl_rel & ~(scl_oe & ~scl_out);
  wire sda = sda_rel & ~(sda_oe & ~sda_out);
  always #50 clock = ~clock;
  smb_client #(.TICK_CYCLES(20)) u_smb_client (.clock(clock), .rst(rst),
    .serial_bus_clock_pin(scl), .serial_bus_clock_pin_out(scl_out), .serial_bus_clock_pin_oe(scl_oe),
    .serial_bus_data_pin(sda), .serial_bus_data_pin_out(sda_out), .serial_bus_data_pin_oe(sda_oe),
    .alternate_link_clock_pin(alt_clk), .alternate_link_enable(alt_en), .address_and_sensor_strap(strap),
    .remote1_thermistor_mode(therm), .alert_event(alert_event), .alert_interrupt_out_n(irq_n),
    .interrupt_output_enable(irq_en));
  smb_host_model host (.clock(clock), .sda(sda), .scl_rel(scl_rel), .sda_rel(sda_rel));
  task automatic close_out();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr_byte(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] dat, input logic ok);
    host.start_cond();
    host.put_byte({a, 1'b0}, k);
    check(k, ok);
    if (ok) begin
      host.put_byte(idx, k);
      check(k, 1'b1);
      host.put_byte(dat, k);
      check(k, 1'b1);
    end
    host.stop_cond();
  endtask : wr_byte
  task automatic rd_byte(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] exp);
    host.start_cond();
    host.put_byte({a, 1'b0}, k);
    check(k, 1'b1);
    host.put_byte(idx, k);
    host.start_cond();
    host.put_byte({a, 1'b1}, k);
    check(k, 1'b1);
    host.get_byte(1'b1, d);
    check(d, exp);
    host.stop_cond();
  endtask : rd_byte
  task automatic addr_only(input logic [7:0] v, input logic ok);
    host.start_cond();
    host.put_byte(v, k);
    check(k, ok);
    host.stop_cond();
  endtask : addr_only
  task automatic t_reset(input logic [1:0] s);
    strap = s;
    rst = 1'b1;
    host.wait_n(2);
    rst = 1'b0;
    host.wait_n(20);
    own = s[STRAP_ADDR_BIT] ? ADDR_STRAP_B : ADDR_STRAP_A;
    check(therm, s[STRAP_THERM_BIT]);
    check(irq_n, 1'b1);
  endtask : t_reset
  task automatic t_rw();
    host.stretch = 60;
    wr_byte(own, 8'h10, 8'ha5, 1'b1);
    host.stretch = 0;
    wr_byte(own, 8'h20, 8'h3c, 1'b1);
    rd_byte(own, 8'h10, 8'ha5);
    addr_only({own, 1'b0}, 1'b1);
    // write cut by a stop in mid data byte: nothing stored, next address acked
    host.start_cond();
    host.put_byte({own, 1'b0}, k);
    host.put_byte(8'h20, k);
    for (int i = 0; i < 4; i++) host.bit_clk(1'b0, k);
    host.stop_cond();
    host.start_cond();
    host.put_byte({own, 1'b0}, k);
    check(k, 1'b1);
    host.put_byte(8'h20, k);
    check(k, 1'b1);
    host.stop_cond();
    host.start_cond();
    host.put_byte({own, 1'b1}, k);
    check(k, 1'b1);
    host.get_byte(1'b1, d);
    check(d, 8'h3c);
    host.stop_cond();
  endtask : t_rw
  task automatic t_alert();
    wr_byte(ADDR_STRAP_B, 8'h10, 8'h00, 1'b0);
    addr_only({ALERT_RESPONSE_ADDR, 1'b0}, 1'b0);
    addr_only({ALERT_RESPONSE_ADDR, 1'b1}, 1'b0);
    rd_byte(own, 8'h10, 8'ha5);
    wr_byte(own, INTERRUPT_OUTPUT_ENABLE_INDEX, 8'h01, 1'b1);
    alert_event = 1'b1;
    host.wait_n(1);
    alert_event = 1'b0;
    host.wait_n(4);
    check(irq_n, 1'b0);
    host.start_cond();
    host.put_byte({ALERT_RESPONSE_ADDR, 1'b1}, k);
    check(k, 1'b1);
    host.get_byte(1'b1, d);
    check(d, {own, 1'b0});
    host.stop_cond();
    check({irq_en, irq_n}, 2'b01);
    rd_byte(own, INTERRUPT_OUTPUT_ENABLE_INDEX, 8'h00);
    addr_only({ALERT_RESPONSE_ADDR, 1'b1}, 1'b0);
    wr_byte(own, INTERRUPT_OUTPUT_ENABLE_INDEX, 8'h01, 1'b1);
    check({irq_en, irq_n}, 2'b10);
  endtask : t_alert
  task automatic t_timeout();
    // clock held low through the ack slot: the device must give the data line back
    host.start_cond();
    d = {own, 1'b0};
    for (int i = 7; i >= 0; i--) host.bit_clk(d[i], k);
    host.stretch = 700;
    host.bit_clk(1'b1, k);
    host.stretch = 0;
    check(k, 1'b1);
    host.stop_cond();
    rd_byte(own, 8'h20, 8'h3c);
  endtask : t_timeout
  task automatic alt_burst();
    repeat (20) begin
      host.wait_n(4);
      alt_clk = ~alt_clk;
    end
  endtask : alt_burst
  task automatic t_alt();
    alt_burst();
    check(alt_en, 1'b0);
    host.wait_n(WAIT_CYC);
    alt_burst();
    check(alt_en, 1'b1);
    host.wait_n(ALT_IDLE_CYCLES + 100);
    check(alt_en, 1'b0);
    addr_only({own, 1'b0}, 1'b0);
    host.wait_n(WAIT_CYC);
    rd_byte(own, 8'h10, 8'ha5);
  endtask : t_alt
  task automatic t_strap();
    t_reset(2'b01);
    wr_byte(ADDR_STRAP_A, 8'h30, 8'h00, 1'b0);
    wr_byte(own, 8'h30, 8'h77, 1'b1);
    rd_byte(own, 8'h30, 8'h77);
  endtask : t_strap
  initial begin
    repeat (80000) @(posedge clock);
    miscompares++;
    close_out();
  end
  initial begin
    alt_clk = 1'b0;
    alert_event = 1'b0;
    t_reset(2'b10);
    t_rw();
    t_alert();
    t_timeout();
    t_alt();
    t_strap();
    close_out();
  end
endmodule : testbench
